// ==== common/mssc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the stop/standby control
`ifndef MSSC_DEFS_SVH
`define MSSC_DEFS_SVH

`define MSSC_OFF_STBY 4'h0
`define MSSC_OFF_STOP_A 4'h4
`define MSSC_OFF_STOP_B 4'h8
`define MSSC_OFF_STATUS 4'hc

`define MSSC_SEL_LSB 8
`define MSSC_SEL_MSB 12
`define MSSC_STBY_ONE_BIT 14
`define MSSC_SEL_RESET 5'h0f

`define MSSC_HALT_EN_BIT 15
`define MSSC_RSVD14_BIT 14
`define MSSC_DMA_STOP_BIT 13
`define MSSC_RSVD12_BIT 12
`define MSSC_STOP_A_RESET 16'h0fff
`define MSSC_STOP_B_RESET 16'hffff
`define MSSC_STOP_A_ZERO_MASK 16'h5000
`define MSSC_STOP_A_CTRL_MASK 16'h2fff
`define MSSC_STOP_B_CTRL_MASK 16'hffff

`define MSSC_WAIT_64 20'h00040
`define MSSC_WAIT_512 20'h00200
`define MSSC_WAIT_1024 20'h00400
`define MSSC_WAIT_2048 20'h00800
`define MSSC_WAIT_4096 20'h01000
`define MSSC_WAIT_16384 16384
`define MSSC_WAIT_32768 32768
`define MSSC_WAIT_65536 65536
`define MSSC_WAIT_131072 131072
`define MSSC_WAIT_262144 262144
`define MSSC_WAIT_524288 524288

`define MSSC_RESP_OKAY 2'h0
`define MSSC_RESP_SLVERR 2'h2

`endif

// ==== common/mssc_pkg.sv ====
// Types of the module stop and standby wait control block
package mssc_pkg;

  typedef enum logic [2:0] {
    MSSC_ST_RUN = 3'h1,
    MSSC_ST_HALT = 3'h2,
    MSSC_ST_SETTLE = 3'h4
  } mssc_state_t;

  typedef struct packed {
    logic [15:0] stop_a;
    logic [15:0] stop_b;
    logic bus_io_halt;
  } mssc_gate_t;

  typedef struct packed {
    logic busy;
    logic done;
  } mssc_settle_t;

endpackage : mssc_pkg

// ==== logic/mssc_ctrl.sv ====
// Module stop registers, all-clock-halt mode and standby settling timer
`timescale 1ns/10ps
`include "mssc_defs.svh"

module mssc_ctrl
  import mssc_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int unsigned WAIT_16384 = `MSSC_WAIT_16384,
  parameter int unsigned WAIT_32768 = `MSSC_WAIT_32768,
  parameter int unsigned WAIT_65536 = `MSSC_WAIT_65536,
  parameter int unsigned WAIT_131072 = `MSSC_WAIT_131072,
  parameter int unsigned WAIT_262144 = `MSSC_WAIT_262144,
  parameter int unsigned WAIT_524288 = `MSSC_WAIT_524288
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic standby_release,
  output mssc_gate_t gate,
  output mssc_settle_t settle
);

  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_have_q;
  logic wr_en;
  logic [4:0] sel_q;
  logic [15:0] stop_a_q;
  logic [15:0] stop_b_q;
  mssc_state_t state_q;
  logic [19:0] cnt_q;
  logic done_q;
  logic all_ok;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [15:0] stop_a_wr;

  function automatic logic [19:0] wait_len(input logic [4:0] code);
    case (code)
      5'h05: wait_len = `MSSC_WAIT_64;
      5'h06: wait_len = `MSSC_WAIT_512;
      5'h07: wait_len = `MSSC_WAIT_1024;
      5'h08: wait_len = `MSSC_WAIT_2048;
      5'h09: wait_len = `MSSC_WAIT_4096;
      5'h0a: wait_len = 20'(WAIT_16384);
      5'h0b: wait_len = 20'(WAIT_32768);
      5'h0c: wait_len = 20'(WAIT_65536);
      5'h0d: wait_len = 20'(WAIT_131072);
      5'h0e: wait_len = 20'(WAIT_262144);
      5'h0f: wait_len = 20'(WAIT_524288);
      // Reserved codes fall back to the longest wait, the safe side for settling
      default: wait_len = 20'(WAIT_524288);
    endcase
  endfunction : wait_len

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  // Write address and data are taken independently, response after both
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSSC_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q == `MSSC_OFF_STBY || aw_addr_q == `MSSC_OFF_STOP_A ||
                      aw_addr_q == `MSSC_OFF_STOP_B || aw_addr_q == `MSSC_OFF_STATUS) ?
                     `MSSC_RESP_OKAY : `MSSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only the select field is stored; the low byte never holds a value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= `MSSC_SEL_RESET;
    end else if (wr_en && aw_addr_q == `MSSC_OFF_STBY && w_strb_q[1]) begin
      sel_q <= w_data_q[`MSSC_SEL_MSB:`MSSC_SEL_LSB];
    end
  end

  assign stop_a_wr = merge16(stop_a_q, w_data_q, w_strb_q) & ~`MSSC_STOP_A_ZERO_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_a_q <= `MSSC_STOP_A_RESET;
    end else if (wr_en && aw_addr_q == `MSSC_OFF_STOP_A) begin
      stop_a_q <= stop_a_wr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_b_q <= `MSSC_STOP_B_RESET;
    end else if (wr_en && aw_addr_q == `MSSC_OFF_STOP_B) begin
      stop_b_q <= merge16(stop_b_q, w_data_q, w_strb_q);
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `MSSC_OFF_STBY: begin
        rd_mux[`MSSC_SEL_MSB:`MSSC_SEL_LSB] = sel_q;
        rd_mux[`MSSC_STBY_ONE_BIT] = 1'b1;
      end
      `MSSC_OFF_STOP_A: rd_mux[15:0] = stop_a_q;
      `MSSC_OFF_STOP_B: rd_mux[15:0] = stop_b_q;
      `MSSC_OFF_STATUS: rd_mux[3:0] = {all_ok, state_q};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MSSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `MSSC_RESP_OKAY : `MSSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Halt is allowed only once every controlled module is already stopped
  assign all_ok = stop_a_q[`MSSC_HALT_EN_BIT] &&
                  ((stop_a_q & `MSSC_STOP_A_CTRL_MASK) == `MSSC_STOP_A_CTRL_MASK) &&
                  ((stop_b_q & `MSSC_STOP_B_CTRL_MASK) == `MSSC_STOP_B_CTRL_MASK);

  // A release from standby overrides any other request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= MSSC_ST_RUN;
    end else begin
      case (state_q)
        MSSC_ST_RUN: begin
          if (standby_release) begin
            state_q <= MSSC_ST_SETTLE;
          end else if (sleep_req && all_ok) begin
            state_q <= MSSC_ST_HALT;
          end
        end
        MSSC_ST_HALT: begin
          if (standby_release) begin
            state_q <= MSSC_ST_SETTLE;
          end else if (wake_req) begin
            state_q <= MSSC_ST_RUN;
          end
        end
        MSSC_ST_SETTLE: begin
          if (cnt_q == 20'h00000) begin
            state_q <= MSSC_ST_RUN;
          end
        end
        default: state_q <= MSSC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 20'h00000;
    end else if (standby_release && state_q != MSSC_ST_SETTLE) begin
      cnt_q <= wait_len(sel_q) - 20'h00001;
    end else if (state_q == MSSC_ST_SETTLE && cnt_q != 20'h00000) begin
      cnt_q <= cnt_q - 20'h00001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= state_q == MSSC_ST_SETTLE && cnt_q == 20'h00000;
    end
  end

  assign gate = '{stop_a: stop_a_q,
                  stop_b: stop_b_q,
                  bus_io_halt: state_q == MSSC_ST_HALT};
  assign settle = '{busy: state_q == MSSC_ST_SETTLE, done: done_q};

  sequence release_s;
    standby_release && state_q != MSSC_ST_SETTLE;
  endsequence

  sequence halt_cause_s;
    state_q == MSSC_ST_RUN && sleep_req && all_ok && !standby_release;
  endsequence

  long_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    release_s and (sel_q == 5'h08) |=> cnt_q == 20'h007ff)
    else $error("Code 01000 did not load a 2048 state wait");

  short_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    release_s and (sel_q == 5'h05) |=> cnt_q == 20'h0003f && settle.busy)
    else $error("Code 00101 did not load a 64 state wait");

  low_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `MSSC_OFF_STBY
    |=> s_axi_rdata[7:0] == 8'h00 && s_axi_rdata[`MSSC_STBY_ONE_BIT])
    else $error("Standby register low byte not zero on read");

  stop_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && aw_addr_q == `MSSC_OFF_STOP_B && w_strb_q == 4'hf
    |=> gate.stop_b == $past(w_data_q[15:0]))
    else $error("Module stop B did not follow the written value");

  halt_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(gate.bus_io_halt) |-> $past(sleep_req) && $past(all_ok))
    else $error("Bus and I/O halted without enable and all modules stopped");

  halt_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_cause_s |=> gate.bus_io_halt)
    else $error("Sleep with all modules stopped did not halt bus and I/O");

  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !gate.stop_a[`MSSC_RSVD14_BIT] && !gate.stop_a[`MSSC_RSVD12_BIT])
    else $error("Reserved stop bit 14 or 12 became set");

  settle_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settle.busy && cnt_q != 20'h00000 && !standby_release
    |=> settle.busy && cnt_q == $past(cnt_q) - 20'h00001)
    else $error("Settling timer did not count down by one");

  settle_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settle.busy && cnt_q == 20'h00000 |=> settle.done && !settle.busy ##1 !settle.done)
    else $error("Settling end did not give a single done pulse");

  dma_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && aw_addr_q == `MSSC_OFF_STOP_A && w_strb_q[1]
    |=> gate.stop_a[`MSSC_DMA_STOP_BIT] == $past(w_data_q[`MSSC_DMA_STOP_BIT]))
    else $error("DMA engine stop bit did not follow the write");

endmodule : mssc_ctrl

// ==== testbench/mssc_ctrl_tb.sv ====
// Self-checking bench for the module stop and standby wait control
`timescale 1ns/10ps
`include "mssc_defs.svh"

module mssc_ctrl_tb
  import mssc_pkg::*;
;
  localparam int LIMIT = 30000;
  localparam logic [19:0] WAITS [11] = '{20'd64, 20'd512, 20'd1024, 20'd2048, 20'd4096,
    20'd16384, 20'd24, 20'd28, 20'd32, 20'd36, 20'd40};
  logic aclk, aresetn;
  logic [3:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sleep_req, wake_req, standby_release;
  logic halt_prev = 1'b0;
  mssc_gate_t gate;
  mssc_settle_t settle;
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  logic [19:0] st_q[$];
  logic hq[$];
  logic [19:0] busy_n = '0;
  logic [15:0] rb;
  int failures, tests_run, cycles;

  // Only the longest waits are shortened, to keep the run brief
  mssc_ctrl #(.WAIT_32768(24), .WAIT_65536(28), .WAIT_131072(32), .WAIT_262144(36),
    .WAIT_524288(40)) i_mssc_ctrl (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_req(sleep_req), .wake_req(wake_req), .standby_release(standby_release),
    .gate(gate), .settle(settle));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic cmp_val(input string what, input logic [33:0] exp, input logic [33:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_cnt(input logic [19:0] exp, input logic [19:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value settle cycles expected %0d seen %0d", exp, got);
    end
  endtask : cmp_cnt

  task automatic results;
    failures += rd_q.size() + wr_q.size() + st_q.size() + hq.size();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Results are matched to the oldest note as they appear
  always @(posedge aclk) begin
    if (aresetn === 1'b1) begin
      if (rvalid === 1'b1 && rready === 1'b1)
        cmp_val("rdata", rd_q.size() ? rd_q.pop_front() : 'x, {rresp, rdata});
      if (bvalid === 1'b1 && bready === 1'b1)
        cmp_val("bresp", wr_q.size() ? wr_q.pop_front() : 'x, {32'h0, bresp});
      if (settle.busy === 1'b1)
        busy_n++;
      if (settle.done === 1'b1) begin
        cmp_cnt(st_q.size() ? st_q.pop_front() : 'x, busy_n);
        busy_n = '0;
      end
      if (gate.bus_io_halt !== halt_prev) begin
        cmp_val("halt", hq.size() ? hq.pop_front() : 'x, {33'h0, gate.bus_io_halt});
        halt_prev = gate.bus_io_halt;
      end
    end
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] resp);
    logic got;
    wr_q.push_back(resp);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Response ready comes after a random delay, then stays until taken
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      got = bvalid === 1'b1 && bready === 1'b1;
      if (got) bready <= 1'b0;
      else if (bvalid === 1'b1 && $urandom % 2 == 1) bready <= 1'b1;
    end while (!got);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [33:0] exp);
    logic got;
    rd_q.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      got = rvalid === 1'b1 && rready === 1'b1;
      if (got) rready <= 1'b0;
      else if (rvalid === 1'b1 && $urandom % 2 == 1) rready <= 1'b1;
    end while (!got);
  endtask : rd

  // Sleep or wake pulse; halt expectations are queued by the caller
  task automatic pulse_sleep(input logic wake);
    if (wake) wake_req <= 1'b1;
    else sleep_req <= 1'b1;
    @(posedge aclk);
    sleep_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_sleep

  task automatic settle_run(input logic [4:0] code, input logic [19:0] n);
    wr(`MSSC_OFF_STBY, {19'h0, code, 8'h00}, 4'h2, `MSSC_RESP_OKAY);
    st_q.push_back(n);
    standby_release <= 1'b1;
    @(posedge aclk);
    standby_release <= 1'b0;
    for (int i = 0; i < n + 8 && settle.done !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
  endtask : settle_run

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, arvalid} = '0;
    {sleep_req, wake_req, standby_release} = '0;
    bready = 1'b0;
    rready = 1'b0;
    void'($urandom(32'hd179));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`MSSC_OFF_STBY, {2'h0, 32'h4f00});
    rd(`MSSC_OFF_STOP_A, {2'h0, 32'h0fff});
    rd(`MSSC_OFF_STOP_B, {2'h0, 32'hffff});
    wr(`MSSC_OFF_STBY, 32'hffff_ffff, 4'hf, `MSSC_RESP_OKAY);
    rd(`MSSC_OFF_STBY, {2'h0, 32'h5f00});
    wr(`MSSC_OFF_STBY, 32'h0000_05a5, 4'h1, `MSSC_RESP_OKAY);
    rd(`MSSC_OFF_STBY, {2'h0, 32'h5f00});
    wr(4'h2, 32'h1234, 4'hf, `MSSC_RESP_SLVERR);
    rd(4'h2, {`MSSC_RESP_SLVERR, 32'h0});
    wr(`MSSC_OFF_STOP_A, 32'hffff, 4'hf, `MSSC_RESP_OKAY);
    rd(`MSSC_OFF_STOP_A, {2'h0, 32'hafff});
    cmp_val("stop_a", {18'h0, 16'hafff}, {18'h0, gate.stop_a});
    wr(`MSSC_OFF_STOP_A, 32'h0000, 4'hf, `MSSC_RESP_OKAY);
    cmp_val("stop_a", 34'h0, {18'h0, gate.stop_a});
    rb = 16'($urandom) & 16'h7fff;
    wr(`MSSC_OFF_STOP_B, {16'h0, rb}, 4'hf, `MSSC_RESP_OKAY);
    rd(`MSSC_OFF_STOP_B, {18'h0, rb});
    cmp_val("stop_b", {18'h0, rb}, {18'h0, gate.stop_b});
    // Halt refused: enable on but at least B module 15 still running
    wr(`MSSC_OFF_STOP_A, 32'hafff, 4'hf, `MSSC_RESP_OKAY);
    pulse_sleep(1'b0);
    wr(`MSSC_OFF_STOP_B, 32'hffff, 4'hf, `MSSC_RESP_OKAY);
    // Halt refused: enable off, all modules stopped
    wr(`MSSC_OFF_STOP_A, 32'h2fff, 4'hf, `MSSC_RESP_OKAY);
    pulse_sleep(1'b0);
    wr(`MSSC_OFF_STOP_A, 32'hafff, 4'hf, `MSSC_RESP_OKAY);
    hq.push_back(1'b1);
    pulse_sleep(1'b0);
    rd(`MSSC_OFF_STATUS, {2'h0, 32'h0000000a});
    hq.push_back(1'b0);
    pulse_sleep(1'b1);
    for (int c = 5; c < 16; c++) settle_run(5'(c), WAITS[c-5]);
    settle_run(5'h03, 20'd40);
    settle_run(5'h10, 20'd40);
    results();
  end
endmodule : mssc_ctrl_tb
